// ===== core/encoder_pkg.sv
// Constants, register map and carrier types of the quadrature encoder interface.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package encoder_pkg;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_POSITION   = 8'h08;
    localparam logic [7:0]  ADDR_MAXPOS     = 8'h0C;
    localparam logic [7:0]  ADDR_CMP0       = 8'h10;
    localparam logic [7:0]  ADDR_CMP1       = 8'h14;
    localparam logic [7:0]  ADDR_CMP2       = 8'h18;
    localparam logic [7:0]  ADDR_INDEX_CNT  = 8'h1C;
    localparam logic [7:0]  ADDR_INDEX_CMP  = 8'h20;
    localparam logic [7:0]  ADDR_VEL_LOAD   = 8'h24;
    localparam logic [7:0]  ADDR_VEL_TIMER  = 8'h28;
    localparam logic [7:0]  ADDR_VEL_CAP    = 8'h2C;
    localparam logic [7:0]  ADDR_VEL_CMP    = 8'h30;
    localparam logic [7:0]  ADDR_FILTER     = 8'h34;
    localparam logic [7:0]  ADDR_INT_STAT   = 8'h38;
    localparam logic [7:0]  ADDR_INT_MASK   = 8'h3C;
    localparam logic [7:0]  ADDR_COMMAND    = 8'h40;

    // Control bit positions
    localparam int CTL_X4       = 0;
    localparam int CTL_CLKDIR   = 1;
    localparam int CTL_IDX_RST  = 2;
    localparam int CTL_INV_DIR  = 3;
    localparam int CTL_WIDTH    = 4;
    // Command bit positions (self clearing)
    localparam int CMD_POS_RST  = 0;
    localparam int CMD_IDX_RST  = 1;
    localparam int CMD_VEL_RST  = 2;

    // Interrupt bit positions
    localparam int IRQ_INDEX    = 0;
    localparam int IRQ_VEL_LOW  = 1;
    localparam int IRQ_VEL_TMO  = 2;
    localparam int IRQ_DIR_ERR  = 3;
    localparam int IRQ_POS0     = 4;
    localparam int IRQ_POS1     = 5;
    localparam int IRQ_POS2     = 6;
    localparam int IRQ_REV0     = 7;
    localparam int IRQ_INDEX_EQ = 8;
    localparam int IRQ_DIR_CHG  = 9;
    localparam int IRQ_WIDTH    = 10;

    localparam int NUM_CMP      = 3;
    localparam int FILT_WIDTH   = 16;

    localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RESET_MAXPOS   = 32'hFFFF_FFFF;
    localparam logic [31:0] RESET_VEL_LOAD = 32'h0001_E848; // 1 ms at 125 MHz
    localparam logic [31:0] ONE_32         = 32'h0000_0001;
    localparam logic [15:0] ONE_16         = 16'h0001;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic index;
    } enc_pins_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_resp_t;
endpackage : encoder_pkg

// ===== core/encoder_interface.sv
// Quadrature encoder interface with Wishbone register access.
// Assumes encoder inputs may be asynchronous; one clock, synchronous active-high reset.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module encoder_interface
(
    input  wire logic                 clk,        // 125 MHz clock
    input  wire logic                 reset,      // Synchronous, active high
    input  wire logic                 wb_cyc_i,   // Wishbone cycle
    input  wire logic                 wb_stb_i,   // Wishbone strobe
    input  wire logic                 wb_we_i,    // Wishbone write enable
    input  wire logic [7:0]           wb_adr_i,   // Wishbone byte address
    input  wire logic [3:0]           wb_sel_i,   // Wishbone byte selects
    input  wire logic [31:0]          wb_dat_i,   // Wishbone write data
    output logic      [31:0]          wb_dat_o,   // Wishbone read data
    output logic                      wb_ack_o,   // Wishbone acknowledge
    input  wire encoder_pkg::enc_pins_t enc_in,   // Phase A/B (or clock/dir) and index
    output logic                      irq         // Level interrupt
);
    // ==========================================================
    // Registers
    logic [encoder_pkg::CTL_WIDTH-1:0]  control;
    logic [31:0]                        position;
    logic [31:0]                        maxpos;
    logic [31:0]                        cmp [encoder_pkg::NUM_CMP];
    logic [31:0]                        index_cnt;
    logic [31:0]                        index_cmp;
    logic [31:0]                        vel_load;
    logic [31:0]                        vel_timer;
    logic [31:0]                        vel_count;
    logic [31:0]                        vel_cap;
    logic [31:0]                        vel_cmp;
    logic [encoder_pkg::FILT_WIDTH-1:0] filt_delay;
    logic [encoder_pkg::IRQ_WIDTH-1:0]  int_stat;
    logic [encoder_pkg::IRQ_WIDTH-1:0]  int_mask;
    logic [encoder_pkg::IRQ_WIDTH-1:0]  events;
    logic [2:0]                         cmd;
    logic                               direction;

    // ==========================================================
    // Bus slave: one wait state, ack drops after one cycle
    logic        bus_req;
    logic        wr_fire;
    logic [31:0] wmask;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_fire = bus_req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    logic [31:0] control_wr;
    logic [31:0] filter_wr;
    logic [31:0] mask_wr;
    assign control_wr = merge(32'(control), wb_dat_i, wmask);
    assign filter_wr  = merge(32'(filt_delay), wb_dat_i, wmask);
    assign mask_wr    = merge(32'(int_mask), wb_dat_i, wmask);

    always_ff @(posedge clk)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = encoder_pkg::RESET_ZERO;
        case (wb_adr_i)
            encoder_pkg::ADDR_CONTROL:   next_rdata = 32'(control);
            encoder_pkg::ADDR_STATUS:    next_rdata = 32'(direction);
            encoder_pkg::ADDR_POSITION:  next_rdata = position;
            encoder_pkg::ADDR_MAXPOS:    next_rdata = maxpos;
            encoder_pkg::ADDR_CMP0:      next_rdata = cmp[0];
            encoder_pkg::ADDR_CMP1:      next_rdata = cmp[1];
            encoder_pkg::ADDR_CMP2:      next_rdata = cmp[2];
            encoder_pkg::ADDR_INDEX_CNT: next_rdata = index_cnt;
            encoder_pkg::ADDR_INDEX_CMP: next_rdata = index_cmp;
            encoder_pkg::ADDR_VEL_LOAD:  next_rdata = vel_load;
            encoder_pkg::ADDR_VEL_TIMER: next_rdata = vel_timer;
            encoder_pkg::ADDR_VEL_CAP:   next_rdata = vel_cap;
            encoder_pkg::ADDR_VEL_CMP:   next_rdata = vel_cmp;
            encoder_pkg::ADDR_FILTER:    next_rdata = 32'(filt_delay);
            encoder_pkg::ADDR_INT_STAT:  next_rdata = 32'(int_stat);
            encoder_pkg::ADDR_INT_MASK:  next_rdata = 32'(int_mask);
            default:                     next_rdata = encoder_pkg::RESET_ZERO;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            wb_dat_o <= encoder_pkg::RESET_ZERO;
        else if (bus_req && !wb_we_i)
            wb_dat_o <= next_rdata;
    end

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            control    <= '0;
            maxpos     <= encoder_pkg::RESET_MAXPOS;
            index_cmp  <= encoder_pkg::RESET_ZERO;
            vel_load   <= encoder_pkg::RESET_VEL_LOAD;
            vel_cmp    <= encoder_pkg::RESET_ZERO;
            filt_delay <= '0;
            int_mask   <= '0;
        end
        else if (wr_fire)
        begin
            case (wb_adr_i)
                encoder_pkg::ADDR_CONTROL:   control <= control_wr[encoder_pkg::CTL_WIDTH-1:0];
                encoder_pkg::ADDR_MAXPOS:    maxpos <= merge(maxpos, wb_dat_i, wmask);
                encoder_pkg::ADDR_INDEX_CMP: index_cmp <= merge(index_cmp, wb_dat_i, wmask);
                encoder_pkg::ADDR_VEL_LOAD:  vel_load <= merge(vel_load, wb_dat_i, wmask);
                encoder_pkg::ADDR_VEL_CMP:   vel_cmp <= merge(vel_cmp, wb_dat_i, wmask);
                encoder_pkg::ADDR_FILTER:    filt_delay <= filter_wr[encoder_pkg::FILT_WIDTH-1:0];
                encoder_pkg::ADDR_INT_MASK:  int_mask <= mask_wr[encoder_pkg::IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < encoder_pkg::NUM_CMP; g++)
        begin : g_cmp_reg
            always_ff @(posedge clk)
            begin
                if (reset)
                    cmp[g] <= encoder_pkg::RESET_ZERO;
                else if (wr_fire && wb_adr_i == encoder_pkg::ADDR_CMP0 + 8'(4 * g))
                    cmp[g] <= merge(cmp[g], wb_dat_i, wmask);
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
            cmd <= '0;
        else if (wr_fire && wb_adr_i == encoder_pkg::ADDR_COMMAND && wb_sel_i[0])
            cmd <= wb_dat_i[2:0];
        else
            cmd <= '0;
    end

    // ==========================================================
    // Synchronise and filter inputs
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] filt;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= enc_in;
            sync2 <= sync1;
        end
    end

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_filter
            logic [encoder_pkg::FILT_WIDTH-1:0] stable_cnt;
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    stable_cnt <= '0;
                    filt[i]    <= 1'b0;
                end
                else if (sync2[i] == filt[i])
                    stable_cnt <= '0;
                else if (stable_cnt >= filt_delay)
                begin
                    filt[i]    <= sync2[i];
                    stable_cnt <= '0;
                end
                else
                    stable_cnt <= stable_cnt + encoder_pkg::ONE_16;
            end
        end
    endgenerate

    // ==========================================================
    // Decode
    logic       pa_d;
    logic       pb_d;
    logic       idx_d;
    logic       pa_edge;
    logic       pb_edge;
    logic       idx_pulse;
    logic       step;
    logic       step_dir;
    logic       dir_err;
    logic       x4;
    logic       clkdir;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pa_d  <= 1'b0;
            pb_d  <= 1'b0;
            idx_d <= 1'b0;
        end
        else
        begin
            pa_d  <= filt[2];
            pb_d  <= filt[1];
            idx_d <= filt[0];
        end
    end

    assign x4        = control[encoder_pkg::CTL_X4];
    assign clkdir    = control[encoder_pkg::CTL_CLKDIR];
    assign pa_edge   = filt[2] ^ pa_d;
    assign pb_edge   = filt[1] ^ pb_d;
    assign idx_pulse = filt[0] && !idx_d;
    assign dir_err   = !clkdir && pa_edge && pb_edge;

    always_comb
    begin
        step     = 1'b0;
        step_dir = 1'b0;
        if (clkdir)
        begin
            step     = filt[2] && !pa_d;
            step_dir = filt[1];
        end
        else if (!dir_err)
        begin
            // Forward when A leads B
            if (pa_edge)
            begin
                step     = 1'b1;
                step_dir = filt[2] ^ filt[1];
            end
            else if (pb_edge && x4)
            begin
                step     = 1'b1;
                step_dir = !(filt[2] ^ filt[1]);
            end
        end
        step_dir = step_dir ^ control[encoder_pkg::CTL_INV_DIR];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            direction <= 1'b0;
        else if (step)
            direction <= step_dir;
    end

    // ==========================================================
    // Position and index counters
    always_ff @(posedge clk)
    begin
        if (reset || cmd[encoder_pkg::CMD_POS_RST])
            position <= encoder_pkg::RESET_ZERO;
        else if (idx_pulse && control[encoder_pkg::CTL_IDX_RST])
            position <= encoder_pkg::RESET_ZERO;
        else if (step && step_dir)
            position <= (position >= maxpos) ? encoder_pkg::RESET_ZERO
                        : position + encoder_pkg::ONE_32;
        else if (step)
            position <= (position == encoder_pkg::RESET_ZERO) ? maxpos
                        : position - encoder_pkg::ONE_32;
    end

    always_ff @(posedge clk)
    begin
        if (reset || cmd[encoder_pkg::CMD_IDX_RST])
            index_cnt <= encoder_pkg::RESET_ZERO;
        else if (idx_pulse)
            index_cnt <= direction ? index_cnt + encoder_pkg::ONE_32
                         : index_cnt - encoder_pkg::ONE_32;
    end

    // ==========================================================
    // Velocity timer and capture
    logic vel_tick;
    assign vel_tick = (vel_timer == encoder_pkg::RESET_ZERO);
    always_ff @(posedge clk)
    begin
        if (reset || cmd[encoder_pkg::CMD_VEL_RST])
        begin
            vel_timer <= vel_load;
            vel_count <= encoder_pkg::RESET_ZERO;
            vel_cap   <= encoder_pkg::RESET_ZERO;
        end
        else if (vel_tick)
        begin
            vel_timer <= vel_load;
            vel_cap   <= vel_count;
            vel_count <= 32'(step);
        end
        else
        begin
            vel_timer <= vel_timer - encoder_pkg::ONE_32;
            if (step)
                vel_count <= vel_count + encoder_pkg::ONE_32;
        end
    end

    // ==========================================================
    // Events and interrupts
    logic [encoder_pkg::NUM_CMP-1:0] pos_hit;
    logic                            idx_hit;
    generate
        for (genvar g = 0; g < encoder_pkg::NUM_CMP; g++)
        begin : g_pos_hit
            assign pos_hit[g] = step && (position == cmp[g]);
        end
    endgenerate
    assign idx_hit = idx_pulse && (index_cnt == index_cmp);

    always_comb
    begin
        events = '0;
        events[encoder_pkg::IRQ_INDEX]    = idx_pulse;
        events[encoder_pkg::IRQ_VEL_LOW]  = vel_tick && (vel_count < vel_cmp);
        events[encoder_pkg::IRQ_VEL_TMO]  = vel_tick;
        events[encoder_pkg::IRQ_DIR_ERR]  = dir_err;
        events[encoder_pkg::IRQ_POS0]     = pos_hit[0];
        events[encoder_pkg::IRQ_POS1]     = pos_hit[1];
        events[encoder_pkg::IRQ_POS2]     = pos_hit[2];
        events[encoder_pkg::IRQ_REV0]     = pos_hit[0] && (index_cnt == index_cmp);
        events[encoder_pkg::IRQ_INDEX_EQ] = idx_hit;
        events[encoder_pkg::IRQ_DIR_CHG]  = step && (step_dir != direction);
    end

    logic [encoder_pkg::IRQ_WIDTH-1:0] clr;
    assign clr = (wr_fire && wb_adr_i == encoder_pkg::ADDR_INT_STAT)
                 ? (wb_dat_i[encoder_pkg::IRQ_WIDTH-1:0] & wmask[encoder_pkg::IRQ_WIDTH-1:0])
                 : '0;
    always_ff @(posedge clk)
    begin
        if (reset)
            int_stat <= '0;
        else
            int_stat <= (int_stat & ~clr) | events;             // Set wins over clear
    end
    assign irq = |(int_stat & int_mask);

    // ==========================================================
    // Assertions
    a_pos_up_step: assert property (@(posedge clk) disable iff (reset)
        step && step_dir && !cmd[encoder_pkg::CMD_POS_RST] && !idx_pulse && position < maxpos
        |=> position == $past(position) + encoder_pkg::ONE_32)
        else $error("position did not count up");
    a_pos_down_step: assert property (@(posedge clk) disable iff (reset)
        step && !step_dir && !cmd[encoder_pkg::CMD_POS_RST] && !idx_pulse
        && position != encoder_pkg::RESET_ZERO
        |=> position == $past(position) - encoder_pkg::ONE_32)
        else $error("position did not count down");
    a_pos_hold_idle: assert property (@(posedge clk) disable iff (reset)
        !step && !idx_pulse && !cmd[encoder_pkg::CMD_POS_RST] |=> $stable(position))
        else $error("position moved without a step");
    a_index_reset: assert property (@(posedge clk) disable iff (reset)
        idx_pulse && control[encoder_pkg::CTL_IDX_RST] |=> position == encoder_pkg::RESET_ZERO)
        else $error("index did not clear position");
    a_both_edges_ignored: assert property (@(posedge clk) disable iff (reset)
        dir_err |-> !step)
        else $error("step taken on double edge");
    a_x2_b_ignored: assert property (@(posedge clk) disable iff (reset)
        !x4 && !clkdir && pb_edge && !pa_edge |-> !step)
        else $error("phase B counted in two-count mode");
    a_vel_capture: assert property (@(posedge clk) disable iff (reset)
        vel_tick && !cmd[encoder_pkg::CMD_VEL_RST] |=> vel_cap == $past(vel_count))
        else $error("velocity not captured");
    a_vel_low_irq: assert property (@(posedge clk) disable iff (reset)
        vel_tick && vel_count < vel_cmp |=> int_stat[encoder_pkg::IRQ_VEL_LOW])
        else $error("low velocity flag missing");
    a_pos_match_irq: assert property (@(posedge clk) disable iff (reset)
        pos_hit[1] |=> int_stat[encoder_pkg::IRQ_POS1])
        else $error("position match flag missing");
    a_index_count: assert property (@(posedge clk) disable iff (reset)
        idx_pulse && direction && !cmd[encoder_pkg::CMD_IDX_RST]
        |=> index_cnt == $past(index_cnt) + encoder_pkg::ONE_32)
        else $error("index count wrong");
    a_filter_delay: assert property (@(posedge clk) disable iff (reset)
        filt_delay != '0 && $changed(sync2[2]) && !$changed(filt[2]) |=> $stable(filt[2]))
        else $error("filter passed glitch too early");
endmodule : encoder_interface

// ===== dv/encoder_wheel.sv
// Behavioural incremental encoder wheel with index channel.
// Assumes the bench pulses go for one clock with count, direction and mode already set.
`timescale 1ns/1ns
module encoder_wheel
#(
    parameter int PERIOD = 8
)
(
    input  wire logic              clk,     // Bench clock
    input  wire logic              go,      // Start a burst of steps
    input  wire logic [7:0]        count,   // Steps in the burst
    input  wire logic              fwd,     // Direction of travel
    input  wire logic              dbl,     // Jump two states at once when going forward
    input  wire logic              cd_mode, // Count clock and direction mode
    input  wire logic              idx_en,  // Index channel present
    output logic                   busy,    // Burst in progress
    output encoder_pkg::enc_pins_t pins     // Wheel outputs
);
    logic [1:0] q    = 2'h0;
    logic [7:0] left = 8'h00;
    int         tmr  = 0;

    assign busy = (left != 8'h00);

    always @(posedge clk)
    begin
        if (go)
        begin
            left <= count;
            tmr  <= 0;
        end
        else if (busy)
        begin
            tmr <= (tmr == PERIOD - 1) ? 0 : tmr + 1;
            if (tmr == PERIOD - 1)
            begin
                left <= left - 8'h01;
                if (!cd_mode)
                    q <= fwd ? q + (dbl ? 2'h2 : 2'h1) : q - 2'h1;
            end
        end
    end

    // Phase A leads phase B going forward; the clock mode drives clock and level together
    assign pins.phase_a = cd_mode ? (busy && tmr < PERIOD / 2) : (q == 2'h1 || q == 2'h2);
    assign pins.phase_b = cd_mode ? fwd : q[1];
    // Index pulses mid-state at the zero state, with the phases steady
    assign pins.index   = idx_en && busy && q == 2'h0 && tmr >= PERIOD / 2;
endmodule : encoder_wheel

// ===== dv/testbench.sv
// Self-checking bench for the quadrature encoder interface.
// Assumes the encoder_wheel model on the encoder pins and a Wishbone master here.
`timescale 1ns/1ns
module testbench;
    logic                   clk   = 1'h0;
    logic                   reset = 1'h1;
    logic                   cyc   = 1'h0;
    logic                   stb   = 1'h0;
    logic                   we    = 1'h0;
    logic [7:0]             adr   = 8'h00;
    logic [31:0]            wdat  = 32'h0000_0000;
    logic [31:0]            rdat;
    logic                   ack;
    logic                   irq;
    logic                   go    = 1'h0;
    logic [7:0]             cnt   = 8'h00;
    logic                   fwd   = 1'h1;
    logic                   dbl   = 1'h0;
    logic                   cd    = 1'h0;
    logic                   idx   = 1'h0;
    logic                   busy;
    logic [31:0]            d;
    int                     mismatches  = 0;
    int                     check_count = 0;
    encoder_pkg::enc_pins_t pins;

    encoder_wheel wheel (.clk(clk), .go(go), .count(cnt), .fwd(fwd), .dbl(dbl),
        .cd_mode(cd), .idx_en(idx), .busy(busy), .pins(pins));
    encoder_interface uut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .enc_in(pins), .irq(irq));

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check

    // Classic single cycle; ack is read before the edge's own updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        do
            @(posedge clk);
        while (ack !== 1'h1);
        d = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask : wb

    task automatic rc(input string name, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        wb(1'h0, a, 32'h0000_0000);
        check(name, e, d & m);
    endtask : rc

    task automatic spin(input logic [7:0] n, input logic f);
        fwd <= f;
        @(posedge clk);
        cnt <= n;
        go  <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        while (busy)
            @(posedge clk);
        repeat (12) @(posedge clk);
    endtask : spin

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // ==========================================
    // Test sequence
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rc("maxpos", encoder_pkg::ADDR_MAXPOS, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rc("vel load", encoder_pkg::ADDR_VEL_LOAD, 32'hFFFF_FFFF, 32'h0001_E848);
        rc("unmapped", 8'h44, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(1'h1, encoder_pkg::ADDR_POSITION, 32'h0000_0005);
        rc("pos ro", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("test reset done");
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0001);
        spin(8'h08, 1'h1);
        rc("x4 up", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0008);
        rc("dir fwd", encoder_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
        spin(8'h04, 1'h0);
        rc("x4 down", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0004);
        spin(8'h05, 1'h0);
        rc("wrap", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        spin(8'h01, 1'h1);
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0000);
        spin(8'h08, 1'h1);
        rc("x2 up", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0004);
        wb(1'h1, encoder_pkg::ADDR_FILTER, 32'h0000_0064);
        spin(8'h08, 1'h1);
        repeat (120) @(posedge clk);
        rc("filtered", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0004);
        wb(1'h1, encoder_pkg::ADDR_FILTER, 32'h0000_0000);
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0001);
        wb(1'h1, encoder_pkg::ADDR_INT_STAT, 32'h0000_03FF);
        dbl <= 1'h1;
        spin(8'h02, 1'h1);
        dbl <= 1'h0;
        rc("double", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0004);
        rc("dir err", encoder_pkg::ADDR_INT_STAT, 32'h0000_0008, 32'h0000_0008);
        $display("test quadrature done");
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0002);
        wb(1'h1, encoder_pkg::ADDR_COMMAND, 32'h0000_0001);
        cd <= 1'h1;
        spin(8'h05, 1'h1);
        spin(8'h02, 1'h0);
        cd <= 1'h0;
        rc("clk dir", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0003);
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0009);
        spin(8'h04, 1'h1);
        rc("inv dir", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rc("dir inv", encoder_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0001);
        wb(1'h1, encoder_pkg::ADDR_COMMAND, 32'h0000_0001);
        wb(1'h1, encoder_pkg::ADDR_CMP0, 32'h0000_0003);
        wb(1'h1, encoder_pkg::ADDR_CMP1, 32'h0000_0064);
        wb(1'h1, encoder_pkg::ADDR_CMP2, 32'h0000_0005);
        wb(1'h1, encoder_pkg::ADDR_INT_STAT, 32'h0000_03FF);
        spin(8'h08, 1'h1);
        rc("pos cmp", encoder_pkg::ADDR_INT_STAT, 32'h0000_00F0, 32'h0000_00D0);
        check("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
        wb(1'h1, encoder_pkg::ADDR_INT_MASK, 32'h0000_0010);
        check("irq set", 32'h0000_0001, {31'h0000_0000, irq});
        wb(1'h1, encoder_pkg::ADDR_INT_STAT, 32'h0000_0010);
        check("irq clear", 32'h0000_0000, {31'h0000_0000, irq});
        $display("test compare done");
        wb(1'h1, encoder_pkg::ADDR_VEL_LOAD, 32'h0000_0014);
        wb(1'h1, encoder_pkg::ADDR_VEL_CMP, 32'h0000_0001);
        wb(1'h1, encoder_pkg::ADDR_COMMAND, 32'h0000_0004);
        wb(1'h1, encoder_pkg::ADDR_INT_STAT, 32'h0000_03FF);
        repeat (60) @(posedge clk);
        rc("vel cap", encoder_pkg::ADDR_VEL_CAP, 32'hFFFF_FFFF, 32'h0000_0000);
        rc("vel irq", encoder_pkg::ADDR_INT_STAT, 32'h0000_0006, 32'h0000_0006);
        $display("test velocity done");
        wb(1'h1, encoder_pkg::ADDR_COMMAND, 32'h0000_0003);
        wb(1'h1, encoder_pkg::ADDR_CONTROL, 32'h0000_0005);
        wb(1'h1, encoder_pkg::ADDR_INDEX_CMP, 32'h0000_0001);
        wb(1'h1, encoder_pkg::ADDR_INT_STAT, 32'h0000_03FF);
        idx <= 1'h1;
        spin(8'h05, 1'h1);
        idx <= 1'h0;
        rc("idx reset", encoder_pkg::ADDR_POSITION, 32'hFFFF_FFFF, 32'h0000_0001);
        rc("idx count", encoder_pkg::ADDR_INDEX_CNT, 32'hFFFF_FFFF, 32'h0000_0002);
        rc("idx irq", encoder_pkg::ADDR_INT_STAT, 32'h0000_0101, 32'h0000_0101);
        $display("test index done");
        close_out();
    end
endmodule : testbench
